// >>> design/edb_stretch_ctrl.sv
// External data-memory bus cycle sequencer with selectable stretch.
//
// Overview of operation
// - Three-bit stretch field selects zero to seven.
// - Stretch zero to seven gives 2..5, 9..12 cycles.
// - On-chip SRAM accesses always take two cycles.
// - Stretch never alters program fetch timing.
// - Stretch field resets to one stretch cycle.
// - Stretch one adds strobe and hold clock.
// - Stretch two, three widen strobe each cycle.
// - Stretch four lengthens address latch strobe.
// - Stretch four holds address two extra cycles.
// - Stretch four widens read and write strobes.
// - Stretch four holds write data extra cycle.
// - Above four only the strobe grows.
// - Strobe width scales with clock divider setting.
// - On-chip SRAM blocks decode at fixed addresses.
// - Frame buffer hits raise frame_sel for the whole access.
`timescale 1ns/1ps
module edb_stretch_ctrl
  import edb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic stretch_wr,
  input wire logic [2:0] stretch_wdata,
  input wire logic clock_multiplier_select,
  input wire logic [1:0] clock_divide_select,
  input wire logic req,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic [2:0] stretch_sel,
  output logic busy,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  output logic int_sel,
  output logic [1:0] int_blk,
  output logic frame_sel,
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  output logic [ADDR_W-1:0] addr_o,
  output logic addr_oe,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe,
  input wire logic [DATA_W-1:0] data_i
);
  edb_dec_if dec_bus ();

  edb_ram_decode edb_ram_decode_inst (
    .dec(dec_bus.dec)
  );

  edb_state_t state_ff, nxt_state;
  logic [2:0] stretch_ff, nxt_stretch;
  logic [2:0] cur_ff, nxt_cur;
  logic [9:0] pre_ff, nxt_pre;
  logic [9:0] pre_max_ff, nxt_pre_max;
  logic [4:0] seg_ff, nxt_seg;
  logic write_ff, nxt_write;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [DATA_W-1:0] wdata_ff, nxt_wdata;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic done_ff, nxt_done;
  logic int_sel_ff, nxt_int_sel;
  logic [1:0] int_blk_ff, nxt_int_blk;
  logic frame_ff, nxt_frame;
  logic ale_ff, nxt_ale;
  logic rd_n_ff, nxt_rd_n;
  logic wr_n_ff, nxt_wr_n;
  logic addr_oe_ff, nxt_addr_oe;
  logic data_oe_ff, nxt_data_oe;
  logic busy_ff, nxt_busy;
  logic [DATA_W-1:0] din_meta_ff, din_sync_ff;
  logic tick;
  logic last;
  logic [4:0] len;
  logic [4:0] dhold;
  logic [9:0] pre_sel;

  // Segment length in phases for a given state and latched stretch value.
  function automatic logic [4:0] seg_len(input edb_state_t st, input logic [2:0] s);
    seg_len = PH_SETUP;
    case (st)
      ST_ALE: seg_len = (s >= STRETCH_SLOW) ? PH_ALE_SLOW : PH_ALE_FAST;
      ST_SETUP: seg_len = PH_SETUP;
      ST_STROBE: seg_len = (s == 3'h0) ? 5'h01 : {1'b0, s, 1'b0};
      ST_HOLD: seg_len = (s == 3'h0) ? PH_HOLD_ZERO : ((s >= STRETCH_SLOW) ? PH_HOLD_SLOW : PH_HOLD_FAST);
      ST_INTERNAL: seg_len = PH_INTERNAL;
      default: seg_len = PH_SETUP;
    endcase
  endfunction : seg_len

  assign dec_bus.addr = req_addr;

  // Data-bus pins come from outside the clock domain.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      din_meta_ff <= 8'h00;
      din_sync_ff <= 8'h00;
    end
    else
    begin
      din_meta_ff <= data_i;
      din_sync_ff <= din_meta_ff;
    end
  end

  // Phase prescale follows only the divider; program fetch never passes through here.
  always_comb
  begin
    pre_sel = PRE_DIV4;
    if (clock_divide_select == CD_BASE)
      pre_sel = clock_multiplier_select ? PRE_X4 : PRE_X2;
    else if (clock_divide_select == CD_DIV1024)
      pre_sel = PRE_DIV1024;
  end

  always_comb
  begin
    tick = (pre_ff == pre_max_ff);
    len = seg_len(state_ff, cur_ff);
    last = tick && (seg_ff == len - 5'h01);
    dhold = (cur_ff == 3'h0) ? PH_HOLD_ZERO : ((cur_ff >= STRETCH_SLOW) ? PH_DHOLD_SLOW : PH_HOLD_FAST);
    nxt_state = state_ff;
    nxt_stretch = stretch_ff;
    nxt_cur = cur_ff;
    nxt_pre = tick ? 10'h000 : pre_ff + 10'h001;
    nxt_pre_max = pre_max_ff;
    nxt_seg = tick ? seg_ff + 5'h01 : seg_ff;
    nxt_write = write_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_rdata = rdata_ff;
    nxt_done = 1'b0;
    nxt_int_sel = int_sel_ff;
    nxt_int_blk = int_blk_ff;
    nxt_frame = frame_ff;
    if (stretch_wr)
      nxt_stretch = stretch_wdata;
    case (state_ff)
      ST_IDLE:
      begin
        nxt_pre = 10'h000;
        nxt_seg = 5'h00;
        if (req)
        begin
          nxt_cur = stretch_ff;
          nxt_pre_max = pre_sel;
          nxt_write = req_write;
          nxt_addr = req_addr;
          nxt_wdata = req_wdata;
          nxt_int_blk = dec_bus.blk;
          nxt_frame = dec_bus.frame_hit;
          nxt_int_sel = dec_bus.hit;
          nxt_state = dec_bus.hit ? ST_INTERNAL : ST_ALE;
        end
      end
      ST_ALE, ST_SETUP, ST_STROBE, ST_HOLD, ST_INTERNAL:
      begin
        if (last)
        begin
          nxt_seg = 5'h00;
          case (state_ff)
            ST_ALE: nxt_state = ST_SETUP;
            ST_SETUP: nxt_state = ST_STROBE;
            ST_STROBE:
            begin
              nxt_state = ST_HOLD;
              if (!write_ff)
                nxt_rdata = din_sync_ff;
            end
            default:
            begin
              nxt_state = ST_IDLE;
              nxt_done = 1'b1;
              nxt_int_sel = 1'b0;
              nxt_frame = 1'b0;
            end
          endcase
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Pin levels follow the next state so each comes straight from a flip-flop.
  always_comb
  begin
    nxt_ale = (nxt_state == ST_ALE);
    nxt_busy = (nxt_state != ST_IDLE);
    nxt_rd_n = !((nxt_state == ST_STROBE) && !nxt_write);
    nxt_wr_n = !((nxt_state == ST_STROBE) && nxt_write);
    nxt_addr_oe = (nxt_state == ST_ALE) || (nxt_state == ST_SETUP) || (nxt_state == ST_STROBE) ||
                  (nxt_state == ST_HOLD);
    nxt_data_oe = nxt_write && ((nxt_state == ST_SETUP) || (nxt_state == ST_STROBE) ||
                  ((nxt_state == ST_HOLD) && (nxt_seg < dhold)));
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= ST_IDLE;
      stretch_ff <= STRETCH_RST;
      cur_ff <= STRETCH_RST;
      pre_ff <= 10'h000;
      pre_max_ff <= 10'h000;
      seg_ff <= 5'h00;
      write_ff <= 1'b0;
      addr_ff <= 24'h000000;
      wdata_ff <= 8'h00;
      rdata_ff <= 8'h00;
      done_ff <= 1'b0;
      int_sel_ff <= 1'b0;
      int_blk_ff <= 2'h0;
      frame_ff <= 1'b0;
      ale_ff <= 1'b0;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
      addr_oe_ff <= 1'b0;
      data_oe_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      stretch_ff <= nxt_stretch;
      cur_ff <= nxt_cur;
      pre_ff <= nxt_pre;
      pre_max_ff <= nxt_pre_max;
      seg_ff <= nxt_seg;
      write_ff <= nxt_write;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
      done_ff <= nxt_done;
      int_sel_ff <= nxt_int_sel;
      int_blk_ff <= nxt_int_blk;
      frame_ff <= nxt_frame;
      ale_ff <= nxt_ale;
      rd_n_ff <= nxt_rd_n;
      wr_n_ff <= nxt_wr_n;
      addr_oe_ff <= nxt_addr_oe;
      data_oe_ff <= nxt_data_oe;
    end
  end

  // Busy mirrors the state register; a request is only taken while idle.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      busy_ff <= 1'b0;
    else
      busy_ff <= nxt_busy;
  end

  assign stretch_sel = stretch_ff;
  assign busy = busy_ff;
  assign done = done_ff;
  assign rdata = rdata_ff;
  assign int_sel = int_sel_ff;
  assign int_blk = int_blk_ff;
  assign frame_sel = frame_ff;
  assign ale = ale_ff;
  assign rd_n = rd_n_ff;
  assign wr_n = wr_n_ff;
  assign addr_o = addr_ff;
  assign addr_oe = addr_oe_ff;
  assign data_o = wdata_ff;
  assign data_oe = data_oe_ff;
endmodule : edb_stretch_ctrl

// >>> pkg/edb_pkg.sv
// Shared constants and types for the external data bus stretch controller.
package edb_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 8;
  localparam logic [2:0] STRETCH_RST = 3'h1;
  localparam logic [2:0] STRETCH_SLOW = 3'h4;
  // Fixed on-chip data SRAM windows, base and size in bytes.
  localparam logic [23:0] DATA_RAM_BASE = 24'h000000;
  localparam logic [23:0] DATA_RAM_SIZE = 24'h010000;
  localparam logic [23:0] STACK_RAM_BASE = 24'h010000;
  localparam logic [23:0] STACK_RAM_SIZE = 24'h000400;
  localparam logic [23:0] MSG_RAM_BASE = 24'h010400;
  localparam logic [23:0] MSG_RAM_SIZE = 24'h000100;
  localparam logic [23:0] FRAME_RAM_BASE = 24'h012000;
  localparam logic [23:0] FRAME_RAM_SIZE = 24'h002000;
  localparam logic [1:0] BLK_DATA = 2'h0;
  localparam logic [1:0] BLK_STACK = 2'h1;
  localparam logic [1:0] BLK_MSG = 2'h2;
  localparam logic [1:0] BLK_FRAME = 2'h3;
  // Phase lengths; one machine cycle is two phases.
  localparam logic [4:0] PH_ALE_FAST = 5'h01;
  localparam logic [4:0] PH_ALE_SLOW = 5'h03;
  localparam logic [4:0] PH_SETUP = 5'h01;
  localparam logic [4:0] PH_HOLD_ZERO = 5'h01;
  localparam logic [4:0] PH_HOLD_FAST = 5'h02;
  localparam logic [4:0] PH_HOLD_SLOW = 5'h06;
  localparam logic [4:0] PH_DHOLD_SLOW = 5'h04;
  localparam logic [4:0] PH_INTERNAL = 5'h04;
  // Oscillator clocks per phase, minus one, for each divider setting.
  localparam logic [9:0] PRE_X4 = 10'h000;
  localparam logic [9:0] PRE_X2 = 10'h000;
  localparam logic [9:0] PRE_DIV4 = 10'h001;
  localparam logic [9:0] PRE_DIV1024 = 10'h1FF;
  localparam logic [1:0] CD_BASE = 2'h0;
  localparam logic [1:0] CD_DIV1024 = 2'h3;
  typedef enum logic [2:0] {ST_IDLE, ST_ALE, ST_SETUP, ST_STROBE, ST_HOLD, ST_INTERNAL} edb_state_t;
endpackage : edb_pkg

// >>> pkg/edb_dec_if.sv
// Carrier between the bus sequencer and the on-chip SRAM decoder.
`timescale 1ns/1ps
interface edb_dec_if;
  logic [23:0] addr;
  logic hit;
  logic frame_hit;
  logic [1:0] blk;
  modport dec (input addr, output hit, output frame_hit, output blk);
  modport user (output addr, input hit, input frame_hit, input blk);
endinterface : edb_dec_if

// >>> design/edb_ram_decode.sv
// Fixed address decoder for the on-chip data SRAM blocks.
`timescale 1ns/1ps
module edb_ram_decode
  import edb_pkg::*;
(
  edb_dec_if.dec dec
);
  function automatic logic in_win(input logic [23:0] a, input logic [23:0] base, input logic [23:0] size);
    in_win = (a >= base) && (a < base + size);
  endfunction : in_win

  always_comb
  begin
    dec.hit = 1'b1;
    dec.frame_hit = 1'b0;
    dec.blk = BLK_DATA;
    if (in_win(dec.addr, FRAME_RAM_BASE, FRAME_RAM_SIZE))
    begin
      dec.blk = BLK_FRAME;
      dec.frame_hit = 1'b1;
    end
    else if (in_win(dec.addr, DATA_RAM_BASE, DATA_RAM_SIZE))
      dec.blk = BLK_DATA;
    else if (in_win(dec.addr, STACK_RAM_BASE, STACK_RAM_SIZE))
      dec.blk = BLK_STACK;
    else if (in_win(dec.addr, MSG_RAM_BASE, MSG_RAM_SIZE))
      dec.blk = BLK_MSG;
    else
      dec.hit = 1'b0;
  end
endmodule : edb_ram_decode

// >>> verification/edb_asserts.sv
// Port checker for the stretch controller.
`timescale 1ns/1ps
module edb_asserts
  import edb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] clock_divide_select,
  input wire logic [2:0] stretch_sel,
  input wire logic busy,
  input wire logic done,
  input wire logic int_sel,
  input wire logic [1:0] int_blk,
  input wire logic frame_sel,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic addr_oe,
  input wire logic data_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_RST_ONE: assert property ($fell(rst) |-> stretch_sel == 3'h1)
    else $error("stretch not one");
  AST_FAST_LEN: assert property ($rose(busy) && !int_sel && stretch_sel == 3'h0 && clock_divide_select == 2'h0
    |-> busy [*4] ##1 (done && !busy)) else $error("bad fast length");
  AST_INT_LEN: assert property ($rose(busy) && int_sel && clock_divide_select == 2'h0 |-> busy [*4] ##1 !busy)
    else $error("bad internal length");
  AST_INT_QUIET: assert property (int_sel |-> !ale && rd_n && wr_n && !addr_oe)
    else $error("pins move on internal");
  AST_RD_STROBE: assert property (!rd_n |-> addr_oe && !ale && !data_oe && wr_n)
    else $error("bad read strobe");
  AST_WR_STROBE: assert property (!wr_n |-> addr_oe && data_oe && !ale)
    else $error("bad write strobe");
  AST_SLOW_ALE: assert property ($rose(ale) && stretch_sel >= STRETCH_SLOW && clock_divide_select == 2'h0
    |-> ale [*3] ##1 !ale) else $error("bad slow latch");
  AST_DONE_ONE: assert property (done |-> !busy ##1 !done)
    else $error("bad done pulse");
  AST_FRAME: assert property (frame_sel |-> int_sel && int_blk == BLK_FRAME)
    else $error("bad frame flag");
  cover property ($rose(busy) && int_sel);
  cover property (!wr_n && stretch_sel == 3'h7);
  cover property (frame_sel);
  cover property ($rose(ale) && clock_divide_select == 2'h3);
endmodule : edb_asserts
bind edb_stretch_ctrl edb_asserts edb_asserts_inst (.clk_sys(clk_sys), .rst(rst),
  .clock_divide_select(clock_divide_select), .stretch_sel(stretch_sel), .busy(busy), .done(done),
  .int_sel(int_sel), .int_blk(int_blk), .frame_sel(frame_sel), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
  .addr_oe(addr_oe), .data_oe(data_oe));

// >>> verification/edb_sram_model.sv
// Small asynchronous SRAM on the far side of the external bus.
`timescale 1ns/1ps
module edb_sram_model
  import edb_pkg::*;
(
  input wire logic slow,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [ADDR_W-1:0] addr_o,
  input wire logic [DATA_W-1:0] data_o,
  input wire logic data_oe,
  output logic [DATA_W-1:0] data_i
);
  logic [7:0] mem [16];
  logic drv;
  initial for (int i = 0; i < 16; i++) mem[i] = 8'hA0 + 8'(i);
  // A slow part answers only under the strobe; a released bus shows the inverse byte, never the old one.
  assign drv = slow ? !rd_n : !data_oe;
  assign data_i = drv ? mem[addr_o[3:0]] : ~mem[addr_o[3:0]];
  always @(posedge wr_n) if (data_oe === 1'b1) mem[addr_o[3:0]] <= data_o;
endmodule : edb_sram_model

// >>> verification/edb_stretch_ctrl_test.sv
// Self-checking bench for the stretch controller.
`timescale 1ns/1ps
module edb_stretch_ctrl_test
  import edb_pkg::*;
;
  logic clk_sys = 1'b0, rst = 1'b1, stretch_wr = 1'b0, req = 1'b0, req_write = 1'b0, slow = 1'b0;
  logic clock_multiplier_select = 1'b1;
  logic [1:0] clock_divide_select = 2'h0;
  logic [2:0] stretch_wdata = 3'h0;
  logic [23:0] req_addr = 24'h000000;
  logic [7:0] req_wdata = 8'h00;
  logic [2:0] stretch_sel;
  logic busy, done, int_sel, frame_sel, ale, rd_n, wr_n, addr_oe, data_oe;
  logic [1:0] int_blk;
  logic [7:0] rdata, data_o, data_i;
  logic [23:0] addr_o;
  logic [7:0] sh [16];
  int error_cnt = 0, check_count = 0, cyc = 0;
  edb_stretch_ctrl edb_stretch_ctrl_inst (.clk_sys(clk_sys), .rst(rst), .stretch_wr(stretch_wr),
    .stretch_wdata(stretch_wdata), .clock_multiplier_select(clock_multiplier_select),
    .clock_divide_select(clock_divide_select), .req(req), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .stretch_sel(stretch_sel), .busy(busy), .done(done), .rdata(rdata),
    .int_sel(int_sel), .int_blk(int_blk), .frame_sel(frame_sel), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
    .addr_o(addr_o), .addr_oe(addr_oe), .data_o(data_o), .data_oe(data_oe), .data_i(data_i));
  edb_sram_model edb_sram_model_inst (.slow(slow), .rd_n(rd_n), .wr_n(wr_n), .addr_o(addr_o),
    .data_o(data_o), .data_oe(data_oe), .data_i(data_i));
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk
  task st(input logic [2:0] v);
    @(posedge clk_sys);
    #1 stretch_wr = 1;
    stretch_wdata = v;
    @(posedge clk_sys);
    #1 stretch_wr = 0;
    chk(stretch_sel, v, "stretch field");
  endtask : st
  // One move; mid below 8 rewrites the stretch and makes an ignored request during the access.
  task automatic acc(input logic w, input logic [23:0] a, input logic [7:0] d, input int s, input int mid);
    int p, n, sw, nb = 0, na = 0, ns = 0, no = 0, nd = 0, nx = 0;
    logic hit, fr, fs = 0;
    logic [1:0] blk, bs = 0;
    logic [7:0] r0;
    p = clock_divide_select == 2'h0 ? 1 : clock_divide_select == 2'h3 ? 512 : 2;
    fr = a >= FRAME_RAM_BASE && a < FRAME_RAM_BASE + FRAME_RAM_SIZE;
    hit = fr || a < MSG_RAM_BASE + MSG_RAM_SIZE;
    blk = fr ? BLK_FRAME : a >= MSG_RAM_BASE ? BLK_MSG : a >= STACK_RAM_BASE ? BLK_STACK : BLK_DATA;
    n = hit ? 2 : s < 4 ? s + 2 : s + 5;
    sw = s == 0 ? 1 : 2 * s;
    r0 = rdata;
    @(posedge clk_sys);
    #1 req = 1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(posedge clk_sys);
    #1 req = 0;
    for (int i = 0; i < 8000 && done !== 1'b1; i++)
    begin
      nb += busy;
      na += ale;
      ns += !rd_n || !wr_n;
      no += addr_oe;
      nd += data_oe;
      fs = fs | (frame_sel === 1'b1);
      nx += (int_sel !== hit) || (addr_oe && addr_o !== a) || (data_oe && data_o !== d);
      if (int_sel === 1'b1) bs = int_blk;
      if (i == 2 && mid < 8)
      begin
        stretch_wr = 1;
        stretch_wdata = 3'(mid);
        req = 1;
      end
      if (i == 3)
      begin
        stretch_wr = 0;
        req = 0;
      end
      @(posedge clk_sys);
      #1;
    end
    chk(nb, 2 * n * p, "busy length");
    chk(na, hit ? 0 : (s >= 4 ? 3 : 1) * p, "latch width");
    chk(ns, hit ? 0 : sw * p, "strobe width");
    chk(no, hit ? 0 : 2 * n * p, "address drive");
    chk(nd, hit || !w ? 0 : (1 + sw + (s == 0 ? 1 : s < 4 ? 2 : 4)) * p, "data drive");
    chk({fs, bs}, hit ? {fr, blk} : 3'h0, "block decode");
    chk(nx, 0, "pin values");
    chk(rdata, w || hit ? r0 : sh[a[3:0]], "read data");
    if (w && !hit) sh[a[3:0]] = d;
    if (mid < 8)
    begin
      @(posedge clk_sys);
      #1 chk(busy, 1'b0, "request while busy");
      chk(stretch_sel, 3'(mid), "field rewritten");
    end
  endtask : acc
  task t_reset;
    chk(stretch_sel, 3'h1, "reset stretch");
    acc(1'b0, 24'h020003, 8'h00, 1, 8);
    $display("t_reset end");
  endtask : t_reset
  task t_table;
    for (int s = 0; s < 8; s++)
    begin
      st(3'(s));
      slow = s >= 2;
      acc(1'b1, 24'h800000 + 24'(s), 8'h5A ^ 8'(s), s, 8);
      acc(1'b0, 24'h800000 + 24'(s), 8'h00, s, 8);
    end
    slow = 0;
    $display("t_table end");
  endtask : t_table
  task automatic t_int;
    logic [23:0] ad [11] = '{24'h000000, 24'h00FFFF, 24'h010000, 24'h0103FF, 24'h010400, 24'h0104FF,
      24'h012000, 24'h013FFF, 24'h010500, 24'h011FFF, 24'h014000};
    st(3'h7);
    for (int i = 0; i < 11; i++) acc(1'(i), ad[i], 8'(i), 7, 8);
    $display("t_int end");
  endtask : t_int
  task t_div;
    clock_multiplier_select = 0;
    st(3'h1);
    for (int k = 0; k < 3; k++)
    begin
      clock_divide_select = 2'(k);
      acc(1'b0, 24'h900001, 8'h00, 1, 8);
    end
    st(3'h0);
    clock_divide_select = 2'h3;
    acc(1'b1, 24'h900002, 8'h77, 0, 8);
    acc(1'b0, 24'h000020, 8'h00, 0, 8);
    clock_divide_select = 2'h0;
    clock_multiplier_select = 1;
    $display("t_div end");
  endtask : t_div
  task t_mid;
    st(3'h4);
    acc(1'b0, 24'h800009, 8'h00, 4, 0);
    acc(1'b0, 24'h80000A, 8'h00, 0, 8);
    $display("t_mid end");
  endtask : t_mid
  initial
  begin
    for (int i = 0; i < 16; i++) sh[i] = 8'hA0 + 8'(i);
    repeat (12) @(posedge clk_sys);
    #1 rst = 0;
    t_reset();
    t_table();
    t_int();
    t_div();
    t_mid();
    give_verdict();
  end
endmodule : edb_stretch_ctrl_test
